// >>> core/pmcs_pkg.sv
// Constants, register map and mode encoding for the power mode clock switch
package pmcs_pkg;

	// Clock and timing
	localparam int CLK_HZ        = 50_000_000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SUB_CLK_HZ    = 32_000;
	localparam int SUB_DIV       = CLK_HZ / SUB_CLK_HZ;
	localparam int HS_SETTLE_NS  = 1000;
	localparam int HS_SETTLE_CYC =
		(HS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W      = 8;
	localparam int SUB_W         = 11;
	localparam logic [SETTLE_W-1:0] HS_SETTLE_LAST =
		SETTLE_W'(HS_SETTLE_CYC - 1);
	localparam logic [SUB_W-1:0]    SUB_DIV_LAST = SUB_W'(SUB_DIV - 1);

	// Register byte offsets
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_HS_OSC_CONTROL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_SYS_CLK_CONTROL = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_HS_FREQ_SELECT = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_POWER_STATUS = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h014;

	// Field positions
	localparam int HOC_ENABLE_BIT   = 0;
	localparam int HOC_STABLE_BIT   = 1;
	localparam int SYS_SLOW_KEEP_BIT = 0;
	localparam int SYS_FAST_KEEP_BIT = 1;
	localparam int SYS_SEL_LSB      = 5;
	localparam int PWR_PD_BIT       = 0;
	localparam int PWR_TMO_BIT      = 1;
	localparam int PWR_MODE_LSB     = 4;
	localparam int PWR_SRC_BIT      = 8;
	localparam int IRQ_SWITCH_BIT   = 0;
	localparam int IRQ_HS_READY_BIT = 1;
	localparam int IRQ_HALT_BIT     = 2;
	localparam int IRQ_W            = 3;

	// Reset values and codes
	localparam logic       HS_ENABLE_RESET = 1'b1;
	localparam logic [2:0] SEL_RESET       = 3'h0;
	localparam logic       KEEP_RESET      = 1'b0;
	localparam logic [2:0] SEL_SUB         = 3'h7;
	localparam logic [1:0] FREQ_SEL_RESET  = 2'h0;

	// Operating modes
	typedef enum logic [2:0] {
		mode_fast,
		mode_slow,
		mode_sleep,
		mode_idle_slow_only,
		mode_idle_both_clocks,
		mode_idle_fast_only
	} pmcs_mode_t;

endpackage

// >>> core/pmcs_osc_settle.sv
// Start-up settle timer producing the fast oscillator stable flag
`timescale 1ns/1ps
module pmcs_osc_settle (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Oscillator control
	input  wire logic osc_on,
	input  wire logic restart,
	// Status
	output logic      stable
);
	import pmcs_pkg::*;

	typedef struct packed {
		logic                on_d;
		logic [SETTLE_W-1:0] cnt;
		logic                stable;
	} pmcs_settle_t;

	pmcs_settle_t r_reg;
	pmcs_settle_t r_next;

	////////////////////////////////////////////////////////////////////
	// Flag drops on enable or frequency change, rises after settle
	always_comb begin
		r_next      = r_reg;
		r_next.on_d = osc_on;
		if (!osc_on || restart || !r_reg.on_d) begin
			r_next.cnt    = '0;
			r_next.stable = 1'b0;
		end else if (r_reg.cnt == HS_SETTLE_LAST) begin
			r_next.stable = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign stable = r_reg.stable;

endmodule

// >>> core/pmcs_top.sv
// Operating mode and oscillator control with APB register access
`timescale 1ns/1ps
module pmcs_top (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [pmcs_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// CPU and watchdog side, same clock
	input  wire logic                  halt_req,
	input  wire logic                  wake_req,
	input  wire logic                  wdt_enable,
	input  wire logic                  wdt_timeout,
	// Slow oscillator ready, from a pin
	input  wire logic                  slow_osc_ready_pin,
	// Clock controls and status
	output logic                       cpu_run,
	output logic                       sysclk_tick,
	output logic                       sysclk_is_sub,
	output logic                       hs_osc_on,
	output logic                       slow_osc_on,
	output logic                       sub_clk_tick,
	output logic [2:0]                 mode_out,
	output logic                       power_down_flag,
	output logic                       watchdog_timeout_flag,
	output logic                       wdt_clear,
	output logic                       irq
);
	import pmcs_pkg::*;

	typedef struct packed {
		logic             hs_en;
		logic [2:0]       sel;
		logic             fast_keep;
		logic             slow_keep;
		logic [1:0]       freq_sel;
		logic             freq_chg;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
		logic             pd_flag;
		logic             tmo;
		pmcs_mode_t       mode;
		logic             src_sub;
		logic [1:0]       ls_sync;
		logic [5:0]       div_cnt;
		logic [SUB_W-1:0] sub_cnt;
		logic             hs_ready_d;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             cpu_run;
		logic             cpu_tick;
		logic             sub_tick;
		logic             wdt_clear;
		logic             hs_on;
		logic             ls_on;
		logic             irq;
	} pmcs_top_state_t;

	pmcs_top_state_t r_reg;
	pmcs_top_state_t r_next;
	logic            hs_stable;

	////////////////////////////////////////////////////////////////////
	// Fast oscillator settle timer
	pmcs_osc_settle u_settle (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.osc_on  (r_reg.hs_on),
		.restart (r_reg.freq_chg),
		.stable  (hs_stable)
	);

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic             ls_ok;
		logic             running;
		logic             wr;
		logic             hit;
		logic [31:0]      rd;
		logic [IRQ_W-1:0] ev;
		logic [5:0]       div_mask;
		logic             sub_wrap;
		ls_ok    = r_reg.ls_sync[1];
		running  = r_reg.cpu_run;
		ev       = '0;
		hit      = 1'b1;
		rd       = 32'h0000_0000;
		r_next   = r_reg;
		r_next.ls_sync   = {r_reg.ls_sync[0], slow_osc_ready_pin};
		r_next.pready    = 1'b0;
		r_next.pslverr   = 1'b0;
		r_next.wdt_clear = 1'b0;
		r_next.freq_chg  = 1'b0;

		// Read mux; unused bits stay zero
		case (paddr)
			OFF_HS_OSC_CONTROL: begin
				rd[HOC_ENABLE_BIT] = r_reg.hs_en;
				rd[HOC_STABLE_BIT] = hs_stable;
			end
			OFF_SYS_CLK_CONTROL: begin
				rd[SYS_SEL_LSB+:3]     = r_reg.sel;
				rd[SYS_FAST_KEEP_BIT]  = r_reg.fast_keep;
				rd[SYS_SLOW_KEEP_BIT]  = r_reg.slow_keep;
			end
			OFF_HS_FREQ_SELECT: rd[1:0] = r_reg.freq_sel;
			OFF_POWER_STATUS: begin
				rd[PWR_PD_BIT]        = r_reg.pd_flag;
				rd[PWR_TMO_BIT]       = r_reg.tmo;
				rd[PWR_MODE_LSB+:3]   = r_reg.mode;
				rd[PWR_SRC_BIT]       = r_reg.src_sub;
			end
			OFF_IRQ_STATUS: rd[IRQ_W-1:0] = r_reg.irq_st;
			OFF_IRQ_MASK:   rd[IRQ_W-1:0] = r_reg.irq_mask;
			default:        hit = 1'b0;
		endcase

		// Answer prepared in setup, shown during one access cycle
		if (psel && !penable) begin
			r_next.pready  = 1'b1;
			r_next.prdata  = pwrite ? 32'h0000_0000 : rd;
			r_next.pslverr = !hit;
		end
		wr = psel && penable && r_reg.pready && pwrite && hit;

		// Register writes; stable flag has no write path
		if (wr) begin
			case (paddr)
				OFF_HS_OSC_CONTROL:
					r_next.hs_en = pwdata[HOC_ENABLE_BIT];
				OFF_SYS_CLK_CONTROL: begin
					r_next.sel       = pwdata[SYS_SEL_LSB+:3];
					r_next.fast_keep = pwdata[SYS_FAST_KEEP_BIT];
					r_next.slow_keep = pwdata[SYS_SLOW_KEEP_BIT];
				end
				OFF_HS_FREQ_SELECT: begin
					r_next.freq_sel = pwdata[1:0];
					r_next.freq_chg = pwdata[1:0] != r_reg.freq_sel;
				end
				OFF_POWER_STATUS: begin
					r_next.pd_flag = r_reg.pd_flag & ~pwdata[PWR_PD_BIT];
					r_next.tmo = r_reg.tmo & ~pwdata[PWR_TMO_BIT];
				end
				OFF_IRQ_STATUS:
					r_next.irq_st = r_reg.irq_st & ~pwdata[IRQ_W-1:0];
				OFF_IRQ_MASK:
					r_next.irq_mask = pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end

		// Source hand-over only to a settled oscillator
		// Mode follows the source so status shows slow or fast at once
		if (running && r_reg.sel == SEL_SUB && !r_reg.src_sub &&
			ls_ok) begin
			r_next.src_sub = 1'b1;
			r_next.mode    = mode_slow;
			ev[IRQ_SWITCH_BIT] = 1'b1;
		end else if (running && r_reg.sel != SEL_SUB && r_reg.src_sub &&
			hs_stable) begin
			r_next.src_sub = 1'b0;
			r_next.mode    = mode_fast;
			ev[IRQ_SWITCH_BIT] = 1'b1;
		end

		// Halt entry; other state is simply left alone
		if (halt_req && running) begin
			case ({r_reg.fast_keep, r_reg.slow_keep})
				2'b00:   r_next.mode = mode_sleep;
				2'b01:   r_next.mode = mode_idle_slow_only;
				2'b11:   r_next.mode = mode_idle_both_clocks;
				default: r_next.mode = mode_idle_fast_only;
			endcase
			r_next.pd_flag   = 1'b1;
			r_next.tmo       = 1'b0;
			r_next.wdt_clear = 1'b1;
			ev[IRQ_HALT_BIT] = 1'b1;
		end else if (wake_req && !running) begin
			r_next.mode = r_reg.src_sub ? mode_slow : mode_fast;
		end
		if (wdt_timeout) begin
			r_next.tmo = 1'b1;                               // Set wins
		end
		r_next.cpu_run = r_next.mode == mode_fast ||
			r_next.mode == mode_slow;

		// Oscillator gating per mode
		case (r_next.mode)
			mode_fast, mode_slow: begin
				r_next.hs_on = r_next.hs_en;
				r_next.ls_on = 1'b1;
			end
			mode_idle_slow_only: begin
				r_next.hs_on = 1'b0;
				r_next.ls_on = 1'b1;
			end
			mode_idle_both_clocks: begin
				r_next.hs_on = 1'b1;
				r_next.ls_on = 1'b1;
			end
			mode_idle_fast_only: begin
				r_next.hs_on = 1'b1;
				r_next.ls_on = wdt_enable;
			end
			default: begin
				r_next.hs_on = 1'b0;
				r_next.ls_on = wdt_enable;
			end
		endcase

		// Sub clock divider; stops when slow oscillator is off
		sub_wrap = r_reg.sub_cnt == SUB_DIV_LAST;
		if (!r_reg.ls_on || !ls_ok || sub_wrap) begin
			r_next.sub_cnt = '0;
		end else begin
			r_next.sub_cnt = r_reg.sub_cnt + 1'b1;
		end
		r_next.sub_tick = r_reg.ls_on && ls_ok && sub_wrap &&
			r_next.mode != mode_idle_fast_only &&
			r_next.mode != mode_sleep;

		// Fast clock divider; tick only from a settled source
		div_mask = 6'((7'h01 << r_reg.sel) - 7'h01);
		r_next.div_cnt = hs_stable ? r_reg.div_cnt + 1'b1 : 6'h00;
		if (!r_next.cpu_run) begin
			r_next.cpu_tick = 1'b0;
		end else if (r_next.src_sub) begin
			r_next.cpu_tick = r_next.sub_tick;
		end else begin
			r_next.cpu_tick = hs_stable &&
				(r_reg.div_cnt & div_mask) == div_mask;
		end

		// Sticky events; set beats a same-cycle clear
		ev[IRQ_HS_READY_BIT] = hs_stable && !r_reg.hs_ready_d;
		r_next.hs_ready_d    = hs_stable;
		r_next.irq_st        = r_next.irq_st | ev;
		r_next.irq           = |(r_next.irq_st & r_next.irq_mask);
	end

	////////////////////////////////////////////////////////////////////
	// State register with documented reset values
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg           <= '0;
			r_reg.hs_en     <= HS_ENABLE_RESET;
			r_reg.sel       <= SEL_RESET;
			r_reg.fast_keep <= KEEP_RESET;
			r_reg.slow_keep <= KEEP_RESET;
			r_reg.freq_sel  <= FREQ_SEL_RESET;
			r_reg.mode      <= mode_fast;
			r_reg.cpu_run   <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign pready                = r_reg.pready;
	assign prdata                = r_reg.prdata;
	assign pslverr               = r_reg.pslverr;
	assign cpu_run               = r_reg.cpu_run;
	assign sysclk_tick           = r_reg.cpu_tick;
	assign sysclk_is_sub         = r_reg.src_sub;
	assign hs_osc_on             = r_reg.hs_on;
	assign slow_osc_on           = r_reg.ls_on;
	assign sub_clk_tick          = r_reg.sub_tick;
	assign mode_out              = r_reg.mode;
	assign power_down_flag       = r_reg.pd_flag;
	assign watchdog_timeout_flag = r_reg.tmo;
	assign wdt_clear             = r_reg.wdt_clear;
	assign irq                   = r_reg.irq;

	////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_hoc_upper_zero;
		psel && penable && pready && !pwrite &&
		paddr == OFF_HS_OSC_CONTROL |-> prdata[31:2] == 30'h0;
	endproperty
	a_hoc_upper_zero: assert property (p_hoc_upper_zero)
		else $error("upper control bits not zero");

	property p_off_unstable;
		!hs_osc_on |=> !hs_stable;
	endproperty
	a_off_unstable: assert property (p_off_unstable)
		else $error("stable flag set while oscillator off");

	property p_enable_drops_flag;
		$rose(hs_osc_on) |=> !hs_stable [*3];
	endproperty
	a_enable_drops_flag: assert property (p_enable_drops_flag)
		else $error("stable flag not cleared on enable");

	property p_slow_needs_ls;
		$rose(sysclk_is_sub) |->
			$past(r_reg.ls_sync[1]) && $past(r_reg.sel) == SEL_SUB;
	endproperty
	a_slow_needs_ls: assert property (p_slow_needs_ls)
		else $error("slow switch without stable sub source");

	property p_fast_needs_hs;
		$fell(sysclk_is_sub) |->
			$past(hs_stable) && $past(r_reg.sel) != SEL_SUB;
	endproperty
	a_fast_needs_hs: assert property (p_fast_needs_hs)
		else $error("fast switch to unstable oscillator");

	property p_halt_flags;
		halt_req && cpu_run && !wdt_timeout |=>
			power_down_flag && !watchdog_timeout_flag && !cpu_run;
	endproperty
	a_halt_flags: assert property (p_halt_flags)
		else $error("halt entry flags wrong");

	property p_halt_wdt_clear;
		halt_req && cpu_run |=> wdt_clear ##1 !wdt_clear;
	endproperty
	a_halt_wdt_clear: assert property (p_halt_wdt_clear)
		else $error("watchdog not cleared once on halt");

	property p_sleep_off;
		r_reg.mode == mode_sleep |-> !hs_osc_on && !sysclk_tick &&
			!sub_clk_tick;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("clock running in sleep");

	property p_idle_both;
		r_reg.mode == mode_idle_both_clocks |->
			hs_osc_on && slow_osc_on && !sysclk_tick;
	endproperty
	a_idle_both: assert property (p_idle_both)
		else $error("idle both clocks wrong");

	property p_idle_slow;
		r_reg.mode == mode_idle_slow_only |-> !hs_osc_on && slow_osc_on;
	endproperty
	a_idle_slow: assert property (p_idle_slow)
		else $error("idle slow only wrong");

	property p_idle_fast;
		r_reg.mode == mode_idle_fast_only |-> hs_osc_on && !sub_clk_tick;
	endproperty
	a_idle_fast: assert property (p_idle_fast)
		else $error("idle fast only wrong");

endmodule

// >>> verification/tb_top.sv
// Register-level testbench for the power mode clock switch
`timescale 1ns/1ps
module tb_top;
	import pmcs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Stimulus signals, all defined at time zero
	logic        ref_clk         = 1'b0;
	logic        rst_n           = 1'b0;
	logic        psel            = 1'b0;
	logic        penable         = 1'b0;
	logic        pwrite          = 1'b0;
	logic [11:0] paddr           = 12'h000;
	logic [31:0] pwdata          = 32'h0;
	logic        halt_req        = 1'b0;
	logic        wake_req        = 1'b0;
	logic        wdt_enable      = 1'b0;
	logic        wdt_timeout     = 1'b0;
	logic        slow_osc_ready_pin = 1'b0;
	logic        pready, pslverr, cpu_run, sysclk_tick, sysclk_is_sub;
	logic        hs_osc_on, slow_osc_on, sub_clk_tick, irq, wdt_clear;
	logic        power_down_flag, watchdog_timeout_flag;
	logic [31:0] prdata;
	logic [2:0]  mode_out;
	int          fails           = 0;
	int          checks          = 0;
	// Expected mode, fast and slow oscillator state per keep-bit pair
	logic [2:0]  md [4]          = '{3'h2, 3'h3, 3'h5, 3'h4};
	logic        hs_e [4]        = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic        ls_e [4]        = '{1'b0, 1'b1, 1'b0, 1'b1};

	`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
		$display("wrong value %s exp %0h got %0h", n, e, g); end end

	always #10 ref_clk = ~ref_clk;

	pmcs_top pmcs_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable),
		.wdt_timeout(wdt_timeout),
		.slow_osc_ready_pin(slow_osc_ready_pin),
		.cpu_run(cpu_run), .sysclk_tick(sysclk_tick),
		.sysclk_is_sub(sysclk_is_sub), .hs_osc_on(hs_osc_on),
		.slow_osc_on(slow_osc_on), .sub_clk_tick(sub_clk_tick),
		.mode_out(mode_out),
		.power_down_flag(power_down_flag),
		.watchdog_timeout_flag(watchdog_timeout_flag),
		.wdt_clear(wdt_clear), .irq(irq));

	////////////////////////////////////////////////////////////////////////
	// Bus helpers; every task is entered and left just after a rising edge
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// One APB transfer; waits on pready, one idle edge after release
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A transfer that never got its answer counts as a mismatch
		`CHK("pready", 1'b1, pready)
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp, input string n);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK(n, exp, q)
	endtask

	// Count system clock ticks over a window; period-independent of phase
	task count_ticks(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge ref_clk);
			if (sysclk_tick === 1'b1)
				c++;
		end
	endtask

	task stop_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#(20 * 20000);
		fails++;
		stop_test;
	end

	// Main sequence
	initial begin
		int          c;
		logic [31:0] q;
		logic        e;
		cyc(6);
		rst_n <= 1'b1;
		cyc(80);
		rd(OFF_HS_OSC_CONTROL, 32'h3, "hoc reset");
		rd(OFF_SYS_CLK_CONTROL, 32'h0, "scc reset");
		// Disable with unused bits 31:2 written high and the read-only stable bit written low
		wr(OFF_HS_OSC_CONTROL, 32'hfffffffc);
		rd(OFF_HS_OSC_CONTROL, 32'h0, "hoc off");
		wr(OFF_HS_OSC_CONTROL, 32'h1);
		rd(OFF_HS_OSC_CONTROL, 32'h1, "hoc start");
		cyc(60);
		rd(OFF_HS_OSC_CONTROL, 32'h3, "hoc settled");
		wr(OFF_HS_FREQ_SELECT, 32'h1);
		rd(OFF_HS_OSC_CONTROL, 32'h1, "hoc retune");
		cyc(60);
		rd(OFF_HS_OSC_CONTROL, 32'h3, "hoc retuned");
		apb(1'b0, 12'h020, 32'h0, q, e);
		`CHK("unmapped err", 1'b1, e)
		$display("test oscillator control done");

		// Every fast divider code
		for (int k = 0; k < 7; k++) begin
			wr(OFF_SYS_CLK_CONTROL, {24'h0, 3'(k), 5'h0});
			cyc(4);
			count_ticks(256, c);
			`CHK("ticks", 256 >> k, c)
			`CHK("sub src", 1'b0, sysclk_is_sub)
		end
		$display("test dividers done");

		// Slow switch held off until the slow oscillator reports ready
		wr(OFF_IRQ_STATUS, 32'h7);
		wr(OFF_IRQ_MASK, 32'h1);
		wr(OFF_SYS_CLK_CONTROL, 32'he0);
		cyc(20);
		`CHK("sub early", 1'b0, sysclk_is_sub)
		slow_osc_ready_pin <= 1'b1;
		cyc(8);
		`CHK("sub src", 1'b1, sysclk_is_sub)
		`CHK("slow mode", 3'h1, mode_out)
		`CHK("switch irq", 1'b1, irq)
		// One sub clock period holds exactly one system tick in slow mode
		count_ticks(SUB_DIV, c);
		`CHK("slow ticks", 1, c)
		do @(posedge ref_clk); while (sysclk_tick !== 1'b1);
		`CHK("sub tick", 1'b1, sub_clk_tick)
		wr(OFF_IRQ_STATUS, 32'h1);
		`CHK("irq cleared", 1'b0, irq)
		// Return to fast with the fast oscillator off: must wait for it
		wr(OFF_HS_OSC_CONTROL, 32'h0);
		wr(OFF_SYS_CLK_CONTROL, 32'h0);
		cyc(20);
		`CHK("sub held", 1'b1, sysclk_is_sub)
		wr(OFF_HS_OSC_CONTROL, 32'h1);
		c = 0;
		do begin
			apb(1'b0, OFF_HS_OSC_CONTROL, 32'h0, q, e);
			c++;
		end while (q[1] !== 1'b1 && c < 40);
		cyc(4);
		`CHK("fast src", 1'b0, sysclk_is_sub)
		`CHK("fast mode", 3'h0, mode_out)
		$display("test mode switch done");

		// Halt with each keep-bit pair; timeout flag set first
		wr(OFF_IRQ_MASK, 32'h4);
		for (int k = 0; k < 4; k++) begin
			wr(OFF_SYS_CLK_CONTROL, {30'h0, 2'(k)});
			wdt_timeout <= 1'b1;
			cyc(1);
			wdt_timeout <= 1'b0;
			halt_req <= 1'b1;
			#1;
			`CHK("tmo set", 1'b1, watchdog_timeout_flag)
			cyc(1);
			halt_req <= 1'b0;
			#1;
			`CHK("cpu stop", 1'b0, cpu_run)
			`CHK("mode", md[k], mode_out)
			`CHK("hs on", hs_e[k], hs_osc_on)
			`CHK("ls on", ls_e[k], slow_osc_on)
			`CHK("pdf", 1'b1, power_down_flag)
			`CHK("tmo", 1'b0, watchdog_timeout_flag)
			`CHK("wdt clr", 1'b1, wdt_clear)
			`CHK("halt irq", 1'b1, irq)
			cyc(1);
			#1;
			`CHK("wdt clr end", 1'b0, wdt_clear)
			cyc(1);
			wake_req <= 1'b1;
			cyc(1);
			wake_req <= 1'b0;
			#1;
			`CHK("cpu run", 1'b1, cpu_run)
			cyc(1);
			rd(OFF_SYS_CLK_CONTROL, {30'h0, 2'(k)}, "scc kept");
			wr(OFF_POWER_STATUS, 32'h3);
			wr(OFF_IRQ_STATUS, 32'h7);
			rd(OFF_POWER_STATUS, 32'h0, "pwr clear");
			`CHK("irq off", 1'b0, irq)
			cyc(60);
		end
		$display("test halt modes done");
		stop_test;
	end
endmodule
